// ===== power_ctrl_model.sv
`timescale 1ns/1ps
module power_ctrl_model (
	input wire logic ref_clk,
	input wire logic sleep,
	input wire logic [4:0] level,
	input wire logic [4:0] accN,
	output logic [4:0] reqN = 5'h1f,
	output logic preq = 1'b0,
	output logic [4:0] pstate = 5'h00
);
	// Collator clock is never stopped here, so edge inputs need no extension
	// Requests fall only while accept is high and rise only once accepted
	always_ff @(posedge ref_clk) begin
		reqN <= sleep ? (reqN & ~accN) : (reqN | ~accN);
		preq <= sleep;
		if (!preq && !sleep) begin
			pstate <= level;
		end
	end
endmodule

// ===== power_handshake_pkg.sv
package power_handshake_pkg;

	localparam int CPU_COUNT = 4;
	localparam int ITS_COUNT = 2;
	localparam int PSTATE_W = 5;
	localparam bit HAS_ITS_QCH = 1'b1;
	localparam bit HAS_PCH = 1'b1;
	localparam int SYNC_STAGES = 2;

	// Q-Channel device state, shared by every channel
	typedef enum logic [1:0] {
		Q_RUN,
		Q_REQUEST,
		Q_STOPPED,
		Q_EXIT
	} qch_state_e;

	// Pins of one Q-Channel toward the controller
	typedef struct packed {
		logic qacceptn;
		logic qdeny;
		logic qactive;
	} qch_out_s;

	typedef struct packed {
		logic paccept;
		logic pdeny;
		logic pactive;
	} pch_out_s;

	typedef struct packed {
		logic [CPU_COUNT-1:0] wake;
		logic [CPU_COUNT-1:0] wakeChk;
	} wake_out_s;

	localparam logic [PSTATE_W-1:0] PSTATE_RESET = 5'h00;

endpackage

// ===== power_handshake_ports.sv
`timescale 1ns/1ps
// Function
// - An inactive core is given lower preference when one of several cores is picked for a shared interrupt.
// - The wake output of a core rises when an interrupt targets it and it has to be woken.
// - A raised wake output stays high until the distribution logic enters its gated state.
// - Each wake output has a check bit so that the pair has odd parity.
// - The collator channel drains all messages in flight before the low-power request is accepted.
// - While the collator low-power state is accepted no collator message is sent until it is exited.
// - Each translation-service block has its own channel to drain its path before power down.
// - The translation-service channel signals are vectors as wide as the block count.
// - The translation-service channels are left out in shared-port monolithic builds.
// - A clock-gating channel covers the domain, with its request synchronized inside.
// - A second channel controls the power interface of the domain crossing bridge.
// - The P-Channel exists only in multichip builds, with its request synchronized inside.
module power_handshake_ports (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [power_handshake_pkg::CPU_COUNT-1:0] cpuActive,
	input wire logic [power_handshake_pkg::CPU_COUNT-1:0] wakeNeed,
	input wire logic [power_handshake_pkg::CPU_COUNT-1:0] spiEligible,
	input wire logic spiPending,
	output logic [power_handshake_pkg::CPU_COUNT-1:0] spiTarget,
	input wire logic distGated,
	output power_handshake_pkg::wake_out_s wakeOut,
	input wire logic colMsgValid,
	output logic colMsgReady,
	input wire logic colMsgInFlight,
	input wire logic qreqnCol_n,
	output power_handshake_pkg::qch_out_s colQch,
	input wire logic [power_handshake_pkg::ITS_COUNT-1:0] qreqnIts_n,
	input wire logic [power_handshake_pkg::ITS_COUNT-1:0] itsInFlight,
	output power_handshake_pkg::qch_out_s [power_handshake_pkg::ITS_COUNT-1:0] itsQch,
	input wire logic clkQreqn_n,
	input wire logic domainBusy,
	output power_handshake_pkg::qch_out_s clkQch,
	input wire logic pwrQreqn_n,
	input wire logic bridgeBusy,
	output power_handshake_pkg::qch_out_s pwrQch,
	input wire logic preq,
	input wire logic [power_handshake_pkg::PSTATE_W-1:0] pstate,
	output power_handshake_pkg::pch_out_s pch,
	output logic [power_handshake_pkg::PSTATE_W-1:0] pstateOut
);
	import power_handshake_pkg::*;

	// ==========================================================
	// Core wake requests
	logic [CPU_COUNT-1:0] wake_r;
	logic [CPU_COUNT-1:0] wakeChk_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wake_r <= '0;
			wakeChk_r <= '1;
		end else if (distGated) begin
			wake_r <= '0;
			wakeChk_r <= '1;
		end else begin
			wake_r <= wake_r | wakeNeed;
			wakeChk_r <= ~(wake_r | wakeNeed);
		end
	end

	assign wakeOut.wake = wake_r;
	assign wakeOut.wakeChk = wakeChk_r;

	// ==========================================================
	// Shared interrupt target choice
	logic [CPU_COUNT-1:0] activeSync1_r;
	logic [CPU_COUNT-1:0] activeSync2_r;
	logic [CPU_COUNT-1:0] target_r;
	logic [CPU_COUNT-1:0] pickSet;
	logic [CPU_COUNT-1:0] pick;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			activeSync1_r <= '0;
			activeSync2_r <= '0;
		end else begin
			activeSync1_r <= cpuActive;
			activeSync2_r <= activeSync1_r;
		end
	end

	// Active eligible cores first; inactive ones only when none are active
	always_comb begin
		pickSet = spiEligible & activeSync2_r;
		if (pickSet == '0) begin
			pickSet = spiEligible;
		end
		pick = pickSet & (~pickSet + 1'b1);
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			target_r <= '0;
		end else if (spiPending) begin
			target_r <= pick;
		end else begin
			target_r <= '0;
		end
	end

	assign spiTarget = target_r;

	// ==========================================================
	// Request synchronisers
	localparam int NQ = 3 + ITS_COUNT;
	logic [NQ-1:0] qreqRaw;
	logic [NQ-1:0] qSync1_r;
	logic [NQ-1:0] qSync2_r;
	logic [NQ-1:0] qBusy;
	logic preqSync1_r;
	logic preqSync2_r;

	assign qreqRaw = {pwrQreqn_n, clkQreqn_n, qreqnCol_n, qreqnIts_n};
	assign qBusy = {bridgeBusy, domainBusy | colMsgInFlight | (|itsInFlight), colMsgInFlight,
		itsInFlight};

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			qSync1_r <= '1;
			qSync2_r <= '1;
			preqSync1_r <= 1'b0;
			preqSync2_r <= 1'b0;
		end else begin
			qSync1_r <= qreqRaw;
			qSync2_r <= qSync1_r;
			preqSync1_r <= preq;
			preqSync2_r <= preqSync1_r;
		end
	end

	// ==========================================================
	// Q-Channel devices: drain before accept, no deny
	qch_state_e qState_r [NQ];
	logic [NQ-1:0] qAccn_r;
	logic [NQ-1:0] qActive_r;

	genvar gi;
	generate
		for (gi = 0; gi < NQ; gi++) begin : g_qch
			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					qState_r[gi] <= Q_RUN;
					qAccn_r[gi] <= 1'b1;
					qActive_r[gi] <= 1'b1;
				end else begin
					qActive_r[gi] <= qBusy[gi] | ~qAccn_r[gi];
					case (qState_r[gi])
						Q_RUN: begin
							if (!qSync2_r[gi]) begin
								qState_r[gi] <= Q_REQUEST;
							end
						end
						Q_REQUEST: begin
							if (!qBusy[gi]) begin
								qState_r[gi] <= Q_STOPPED;
								qAccn_r[gi] <= 1'b0;
							end
						end
						Q_STOPPED: begin
							if (qSync2_r[gi]) begin
								qState_r[gi] <= Q_EXIT;
								qAccn_r[gi] <= 1'b1;
							end
						end
						Q_EXIT: begin
							qState_r[gi] <= Q_RUN;
						end
						default: begin
							qState_r[gi] <= Q_RUN;
						end
					endcase
				end
			end
		end
	endgenerate

	// Collator messages held while its low-power request is pending or accepted
	logic colReady_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			colReady_r <= 1'b1;
		end else begin
			colReady_r <= (qState_r[ITS_COUNT] == Q_RUN) && qSync2_r[ITS_COUNT];
		end
	end

	assign colMsgReady = colReady_r & colMsgValid;

	generate
		for (gi = 0; gi < ITS_COUNT; gi++) begin : g_its
			if (HAS_ITS_QCH) begin : g_on
				assign itsQch[gi] = '{qAccn_r[gi], 1'b0, qActive_r[gi]};
			end else begin : g_off
				assign itsQch[gi] = '{1'b1, 1'b0, 1'b0};
			end
		end
	endgenerate

	assign colQch = '{qAccn_r[ITS_COUNT], 1'b0, qActive_r[ITS_COUNT]};
	assign clkQch = '{qAccn_r[ITS_COUNT+1], 1'b0, qActive_r[ITS_COUNT+1]};
	assign pwrQch = '{qAccn_r[ITS_COUNT+2], 1'b0, qActive_r[ITS_COUNT+2]};

	// ==========================================================
	// P-Channel: accept every request once synchronised
	logic pAccept_r;
	logic pActive_r;
	logic [PSTATE_W-1:0] pstate_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pAccept_r <= 1'b0;
			pActive_r <= 1'b0;
			pstate_r <= PSTATE_RESET;
		end else begin
			pAccept_r <= HAS_PCH & preqSync2_r;
			pActive_r <= HAS_PCH & (domainBusy | colMsgInFlight);
			if (HAS_PCH && preqSync2_r && !pAccept_r) begin
				pstate_r <= pstate;
			end
		end
	end

	assign pch = '{pAccept_r, 1'b0, pActive_r};
	assign pstateOut = pstate_r;

endmodule

// ===== power_monitor.sv
`timescale 1ns/1ps
module power_monitor
	import power_handshake_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [CPU_COUNT-1:0] wakeNeed,
	input wire logic distGated,
	input wire wake_out_s wakeOut,
	input wire logic colMsgInFlight,
	input wire logic colMsgReady,
	input wire qch_out_s colQch,
	input wire logic [ITS_COUNT-1:0] itsInFlight,
	input wire qch_out_s [ITS_COUNT-1:0] itsQch,
	input wire logic domainBusy,
	input wire qch_out_s clkQch,
	input wire logic bridgeBusy,
	input wire qch_out_s pwrQch,
	input wire logic preq,
	input wire pch_out_s pch
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_wake_set: assert property (wakeNeed != 0 && !distGated |=>
		(wakeOut.wake & $past(wakeNeed)) == $past(wakeNeed)) else $error("wake not set");
	a_wake_sticky: assert property (|($past(wakeOut.wake) & ~wakeOut.wake)
		|-> $past(distGated)) else $error("wake dropped");
	a_wake_parity: assert property (wakeOut.wakeChk == ~wakeOut.wake)
		else $error("wake parity");
	a_col_drain: assert property ($fell(colQch.qacceptn) |-> !$past(colMsgInFlight))
		else $error("collator not drained");
	a_col_quiet: assert property (!colQch.qacceptn |-> !colMsgReady)
		else $error("collator sends while stopped");
	a_its_drain: assert property ($fell(itsQch[0].qacceptn) |-> !$past(itsInFlight[0]))
		else $error("its path not drained");
	a_clk_idle: assert property ($fell(clkQch.qacceptn) |-> !$past(domainBusy)
		&& !$past(colMsgInFlight) && $past(itsInFlight) == 0) else $error("clock gated busy");
	a_pwr_idle: assert property ($fell(pwrQch.qacceptn) |-> !$past(bridgeBusy))
		else $error("bridge busy");
	a_pch_sync: assert property ($rose(pch.paccept) |-> $past(preq, 3))
		else $error("paccept early");
endmodule

bind power_handshake_ports power_monitor power_monitor_inst (.ref_clk, .rstn, .wakeNeed,
	.distGated, .wakeOut, .colMsgInFlight, .colMsgReady, .colQch, .itsInFlight, .itsQch,
	.domainBusy, .clkQch, .bridgeBusy, .pwrQch, .preq, .pch);

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import power_handshake_pkg::*;
	logic ref_clk = 0;
	logic rstn = 0;
	logic [3:0] cpuActive = 0, wakeNeed = 0, spiEligible = 0, spiTarget;
	logic spiPending = 1, distGated = 0, colMsgValid = 1, colMsgInFlight = 0;
	logic domainBusy = 0, bridgeBusy = 0, sleep = 0, colMsgReady, preq;
	logic [1:0] itsInFlight = 0;
	logic [4:0] level = 5'h0b, reqN, pstate, pstateOut;
	wake_out_s wakeOut;
	qch_out_s colQch, clkQch, pwrQch;
	qch_out_s [1:0] itsQch;
	pch_out_s pch;
	wire [4:0] accN = {colQch.qacceptn, itsQch[1].qacceptn, itsQch[0].qacceptn,
		clkQch.qacceptn, pwrQch.qacceptn};
	int n_errors = 0, compares = 0, cyc = 0;
	always #50 ref_clk = ~ref_clk;
	power_handshake_ports power_handshake_ports_inst (.ref_clk, .rstn, .cpuActive, .wakeNeed,
		.spiEligible, .spiPending, .spiTarget, .distGated, .wakeOut, .colMsgValid,
		.colMsgReady, .colMsgInFlight, .qreqnCol_n(reqN[4]), .colQch, .qreqnIts_n(reqN[3:2]),
		.itsInFlight, .itsQch, .clkQreqn_n(reqN[1]), .domainBusy, .clkQch,
		.pwrQreqn_n(reqN[0]), .bridgeBusy, .pwrQch, .preq, .pstate, .pch, .pstateOut);
	power_ctrl_model power_ctrl_model_inst (.ref_clk, .sleep, .level, .accN, .reqN, .preq,
		.pstate);
	// ==========
	// Helpers
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task wait_acc(input logic [4:0] v);
		for (int i = 0; i < 40 && accN !== v; i++) tick(1);
	endtask
	task wrap_up;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========
	// Scenarios
	task wake_test;
		@(posedge ref_clk) wakeNeed <= 4'h5;
		@(posedge ref_clk) wakeNeed <= 4'h0;
		tick(3);
		chk(wakeOut.wake, 4'h5);
		chk(wakeOut.wakeChk, 4'ha);
		@(posedge ref_clk) distGated <= 1'b1;
		@(posedge ref_clk) distGated <= 1'b0;
		tick(1);
		chk(wakeOut.wake, 4'h0);
		chk(wakeOut.wakeChk, 4'hf);
	endtask
	task target_test;
		@(posedge ref_clk) cpuActive <= 4'ha;
		spiEligible <= 4'hb;
		tick(5);
		chk(spiTarget, 4'h2);
		@(posedge ref_clk) spiEligible <= 4'h5;
		tick(3);
		chk(spiTarget, 4'h1);
		@(posedge ref_clk) spiPending <= 1'b0;
		tick(1);
		chk(spiTarget, 4'h0);
		@(posedge ref_clk) spiPending <= 1'b1;
	endtask
	task sleep_test;
		@(posedge ref_clk) {colMsgInFlight, itsInFlight, domainBusy, bridgeBusy} <= 5'h1f;
		sleep <= 1'b1;
		tick(10);
		chk(accN, 5'h1f);
		chk(colQch.qactive, 1'b1);
		chk(clkQch.qdeny, 1'b0);
		@(posedge ref_clk) {colMsgInFlight, itsInFlight, domainBusy, bridgeBusy} <= 5'h00;
		wait_acc(5'h00);
		chk(accN, 5'h00);
		chk(colMsgReady, 1'b0);
		chk(pch.paccept, 1'b1);
		chk(pstateOut, level);
		@(posedge ref_clk) sleep <= 1'b0;
		wait_acc(5'h1f);
		tick(2);
		chk(colMsgReady, 1'b1);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		tick(3);
		wake_test();
		target_test();
		sleep_test();
		wrap_up();
	end
endmodule
